// File: src/sfsr_pkg.sv
// Shared constants and types for the serial flash soft reset block
package sfsr_pkg;
   // ----------------------------------------------------------------
   // Command opcodes and the erased and idle data bytes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_ARM_RESET = 8'h66;
   localparam logic [7:0] OP_RESET = 8'h99;
   localparam logic [7:0] OP_READ_PARAM_TABLE = 8'h5A;
   localparam logic [7:0] OP_READ_ARRAY = 8'h03;
   localparam logic [7:0] OP_READ_STATUS_LO = 8'h05;
   localparam logic [7:0] OP_READ_STATUS_HI = 8'h35;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] IDLE_BYTE = 8'h00;

   // ----------------------------------------------------------------
   // Frame byte positions
   // ----------------------------------------------------------------
   localparam logic [7:0] BYTE_OPCODE = 8'h00;
   localparam logic [7:0] BYTE_ADDR_LAST = 8'h03;
   localparam logic [7:0] BYTE_TABLE_DATA = 8'h05;
   localparam logic [7:0] BYTE_ARRAY_DATA = 8'h04;
   localparam logic [7:0] FRAME_ONE_BYTE = 8'h01;

   // ----------------------------------------------------------------
   // Status register layout
   // ----------------------------------------------------------------
   localparam int ST_WIP = 0;
   localparam int ST_WEL = 1;
   localparam int ST_QE = 9;
   localparam int ST_SUSPEND_FLAG_TWO = 10;
   localparam int ST_SUSPEND_FLAG_ONE = 15;
   localparam logic [15:0] STATUS_DELIVERED = 16'h0200;

   // ----------------------------------------------------------------
   // APB register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_VOLATILE = 8'h08;
   localparam logic [7:0] ADDR_CYCLE = 8'h0C;
   localparam int CTRL_START = 0;
   localparam int STS_ARMED = 16;
   localparam int STS_RECOVER = 17;
   localparam logic [15:0] CYCLE_RESET = 16'h0100;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int RECOVERY_NS_DEFAULT = 30000;

   // Volatile settings dropped by an accepted reset
   typedef struct packed {
      logic suspend_flag_two;
      logic suspend_flag_one;
      logic deep_power_down;
      logic [2:0] wrap_setting_bits;
      logic [7:0] continuous_read_bits;
      logic [7:0] read_parameter_bits;
   } sfsr_vol_t;

   localparam sfsr_vol_t VOL_RESET = '0;

   // Serial frame events from the shifter
   typedef struct packed {
      logic byte_done;
      logic frame_end;
      logic [7:0] rx_byte;
      logic [7:0] byte_index;
   } sfsr_frame_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARMED = 2'b01,
      ST_RECOVER = 2'b10
   } sfsr_state_t;
endpackage

// File: src/sfsr_shifter.sv
// Serial frame shifter: bytes in on clock rise, bytes out on clock fall
`timescale 1ns/1ps
module sfsr_shifter (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic [7:0] tx_byte,
   output sfsr_pkg::sfsr_frame_t frame,
   output logic so
);
   import sfsr_pkg::*;

   logic sck_prev;
   logic cs_prev;
   logic [2:0] bit_count;
   logic [6:0] rx_shift;
   logic [7:0] tx_shift;
   wire sck_rise = ~cs_n & sck & ~sck_prev;
   wire sck_fall = ~cs_n & ~sck & sck_prev;
   wire last_bit = bit_count == 3'd7;
   wire [7:0] next_byte = {rx_shift, si};

   always_ff @(posedge clk) begin
      if (rst) begin
         sck_prev <= 1'b0;
         cs_prev <= 1'b1;
         bit_count <= 3'd0;
         rx_shift <= 7'd0;
         tx_shift <= 8'd0;
         frame <= '0;
         so <= 1'b0;
      end else begin
         sck_prev <= sck;
         cs_prev <= cs_n;
         frame.byte_done <= sck_rise & last_bit;
         frame.frame_end <= cs_n & ~cs_prev;
         if (cs_n) begin
            bit_count <= 3'd0;
         end else if (sck_rise) begin
            bit_count <= bit_count + 3'd1;
            rx_shift <= next_byte[6:0];
            if (last_bit) begin
               frame.rx_byte <= next_byte;
            end
         end
         // Byte index moves one cycle after the byte lands
         if (frame.byte_done && frame.byte_index != 8'hFF) begin
            frame.byte_index <= frame.byte_index + 8'd1;
         end
         // Cleared at frame start so the byte total stands at frame end
         if (~cs_n & cs_prev) begin
            frame.byte_index <= 8'd0;
         end
         // Load on the last fall of each byte, so tx_byte has settled
         if (sck_fall) begin
            if (bit_count == 3'd0) begin
               tx_shift <= tx_byte;
               so <= tx_byte[7];
            end else begin
               tx_shift <= {tx_shift[6:0], 1'b0};
               so <= tx_shift[6];
            end
         end
      end
   end
endmodule

// File: src/sfsr_top.sv
// Soft reset command handler of a serial flash, with APB status window
`timescale 1ns/1ps
module sfsr_top #(
   parameter int RECOVERY_NS = sfsr_pkg::RECOVERY_NS_DEFAULT
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CS_N,
   input wire logic SCK,
   input wire logic SI,
   output logic SO,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic WIP_OUT
);
   import sfsr_pkg::*;

   // Least time, so round up to whole cycles
   localparam int RECOVERY_CYCLES_RAW =
      (RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RECOVERY_CYCLES =
      RECOVERY_CYCLES_RAW < 1 ? 1 : RECOVERY_CYCLES_RAW;
   localparam logic [23:0] RECOVERY_LOAD = 24'(RECOVERY_CYCLES);

   // ----------------------------------------------------------------
   // Parameter table contents
   // ----------------------------------------------------------------
   function automatic logic [7:0] table_byte(input logic [7:0] addr);
      logic [7:0] rom [0:15];
      rom = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h00, 8'hFF,
              8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hFF};
      table_byte = addr[7:4] == 4'h0 ? rom[addr[3:0]] : ERASED_BYTE;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   sfsr_frame_t frame;
   sfsr_state_t state;
   sfsr_state_t next_state;
   sfsr_vol_t vol;
   logic [7:0] opcode;
   logic [7:0] table_addr;
   logic [23:0] recover_count;
   logic [15:0] busy_count;
   logic [15:0] cycle_len;
   logic write_enable_latch;
   logic quad_enable_bit;
   logic [7:0] tx_byte;

   sfsr_shifter u_shifter (
      .clk(CLK),
      .rst(RST),
      .cs_n(CS_N),
      .sck(SCK),
      .si(SI),
      .tx_byte(tx_byte),
      .frame(frame),
      .so(SO)
   );

   wire recovering = state == ST_RECOVER;
   wire write_in_progress = busy_count != 16'd0;
   wire [15:0] status_word = {vol.suspend_flag_one, 4'h0, vol.suspend_flag_two, quad_enable_bit,
                              7'h00, write_enable_latch, write_in_progress};
   wire one_byte_frame = frame.frame_end &&
                         frame.byte_index == FRAME_ONE_BYTE;
   wire arm_frame = one_byte_frame && opcode == OP_ARM_RESET;
   wire reset_frame = one_byte_frame && opcode == OP_RESET;
   wire reset_accept = state == ST_ARMED && reset_frame && !recovering;
   wire frame_live = !recovering && !vol.deep_power_down;

   // ----------------------------------------------------------------
   // Arm and recovery sequencing
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (arm_frame) begin
               next_state = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (reset_accept) begin
               next_state = ST_RECOVER;
            end else if (frame.frame_end && !arm_frame) begin
               next_state = ST_IDLE;
            end
         end
         ST_RECOVER: begin
            if (recover_count == 24'd1) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Frames arriving during recovery are dropped whole
   always_ff @(posedge CLK) begin
      if (RST) begin
         state <= ST_IDLE;
         recover_count <= 24'd0;
      end else begin
         state <= next_state;
         if (reset_accept) begin
            recover_count <= RECOVERY_LOAD;
         end else if (recover_count != 24'd0) begin
            recover_count <= recover_count - 24'd1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Opcode capture and read data
   // ----------------------------------------------------------------
   wire opcode_byte = frame.byte_done && frame.byte_index == BYTE_OPCODE;
   wire addr_byte = frame.byte_done && frame.byte_index != BYTE_OPCODE &&
                    frame.byte_index <= BYTE_ADDR_LAST;
   wire table_data = opcode == OP_READ_PARAM_TABLE &&
                     frame.byte_index >= BYTE_TABLE_DATA;
   wire array_data = opcode == OP_READ_ARRAY &&
                     frame.byte_index >= BYTE_ARRAY_DATA;

   always_ff @(posedge CLK) begin
      if (RST) begin
         opcode <= 8'h00;
         table_addr <= 8'h00;
      end else begin
         if (opcode_byte) begin
            // A dropped opcode can neither arm nor fire
            opcode <= frame_live ? frame.rx_byte : 8'h00;
         end
         if (addr_byte) begin
            table_addr <= frame.rx_byte;
         end else if (frame.byte_done && table_data) begin
            table_addr <= table_addr + 8'h01;
         end
      end
   end

   always_comb begin
      tx_byte = IDLE_BYTE;
      if (frame_live) begin
         if (frame.byte_index != BYTE_OPCODE) begin
            case (opcode)
               OP_READ_STATUS_LO: tx_byte = status_word[7:0];
               OP_READ_STATUS_HI: tx_byte = status_word[15:8];
               default: tx_byte = IDLE_BYTE;
            endcase
         end
         if (table_data) begin
            tx_byte = table_byte(table_addr);
         end else if (array_data) begin
            tx_byte = ERASED_BYTE;
         end
      end
   end

   // ----------------------------------------------------------------
   // Status, volatile settings and internal cycle
   // ----------------------------------------------------------------
   wire apb_write = PSEL && PENABLE && PREADY && PWRITE;
   wire start_cycle = apb_write && PADDR == ADDR_CTRL &&
                      PWDATA[CTRL_START] && frame_live;

   always_ff @(posedge CLK) begin
      if (RST) begin
         quad_enable_bit <= STATUS_DELIVERED[ST_QE];
         write_enable_latch <= STATUS_DELIVERED[ST_WEL];
         vol <= VOL_RESET;
         busy_count <= 16'd0;
         cycle_len <= CYCLE_RESET;
      end else if (reset_accept) begin
         // No data protection for an aborted cycle
         busy_count <= 16'd0;
         write_enable_latch <= 1'b0;
         vol <= VOL_RESET;
      end else begin
         if (start_cycle) begin
            busy_count <= cycle_len;
         end else if (write_in_progress && !vol.suspend_flag_one && !vol.suspend_flag_two) begin
            busy_count <= busy_count - 16'd1;
            if (busy_count == 16'd1) begin
               write_enable_latch <= 1'b0;
            end
         end
         // Set placed last: a new latch wins over the end-of-cycle clear
         if (one_byte_frame && frame_live &&
             opcode == OP_WRITE_ENABLE) begin
            write_enable_latch <= 1'b1;
         end
         if (apb_write && PADDR == ADDR_VOLATILE) begin
            vol <= sfsr_vol_t'(PWDATA[$bits(sfsr_vol_t)-1:0]);
         end
         if (apb_write && PADDR == ADDR_CYCLE) begin
            cycle_len <= PWDATA[15:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // APB slave: zero wait states, read data captured at setup
   // ----------------------------------------------------------------
   wire setup = PSEL && !PENABLE;
   wire mapped = PADDR == ADDR_STATUS || PADDR == ADDR_CTRL ||
                 PADDR == ADDR_VOLATILE || PADDR == ADDR_CYCLE;
   wire [31:0] read_mux =
      PADDR == ADDR_STATUS ? {14'h0000, recovering, state == ST_ARMED,
                              status_word} :
      PADDR == ADDR_VOLATILE ? 32'(vol) :
      PADDR == ADDR_CYCLE ? {16'h0000, cycle_len} : 32'h0000_0000;

   always_ff @(posedge CLK) begin
      if (RST) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0000_0000;
         WIP_OUT <= 1'b0;
      end else begin
         PREADY <= setup;
         PSLVERR <= setup && !mapped;
         if (setup) begin
            PRDATA <= PWRITE ? 32'h0000_0000 : read_mux;
         end
         WIP_OUT <= write_in_progress;
      end
   end
endmodule

// File: tb/sfsr_sva.sv
// Port-level assertions for the serial flash soft reset block
`timescale 1ns/1ps
module sfsr_sva
   import sfsr_pkg::*;
#(
   parameter int RECOVERY_NS = 40
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CS_N,
   input wire logic SCK,
   input wire logic SI,
   input wire logic SO,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic WIP_OUT
);
   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire setup = PSEL && !PENABLE;
   wire rd_st = PREADY && !PWRITE && PADDR == ADDR_STATUS;
   wire mapped = PADDR inside {ADDR_STATUS, ADDR_CTRL, ADDR_VOLATILE,
                               ADDR_CYCLE};

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   chk_rdy_next: assert property (setup |=> PREADY && PSEL && PENABLE)
      else $error("no ready after setup");
   chk_rdy_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   chk_err_unmap: assert property (setup && !mapped |=> PSLVERR)
      else $error("unmapped address not refused");
   chk_err_ok: assert property (setup && mapped |=> !PSLVERR)
      else $error("mapped address refused");
   chk_err_zero: assert property (PSLVERR |-> PRDATA == 32'h0000_0000)
      else $error("refused read carries data");
   chk_ctrl_zero: assert property
      (PREADY && !PWRITE && PADDR == ADDR_CTRL |-> PRDATA == 32'h0000_0000)
      else $error("control word reads nonzero");
   chk_qe_kept: assert property (rd_st |-> PRDATA[ST_QE])
      else $error("quad enable bit lost");
   chk_recover_clean: assert property (rd_st && PRDATA[STS_RECOVER] |->
      !PRDATA[ST_WIP] && !PRDATA[ST_WEL] && !PRDATA[ST_SUSPEND_FLAG_ONE] &&
      !PRDATA[ST_SUSPEND_FLAG_TWO]) else $error("volatile bits survive reset");
   chk_recover_disarm: assert property
      (rd_st && PRDATA[STS_RECOVER] |-> !PRDATA[STS_ARMED])
      else $error("armed during recovery");
   chk_reset_quiet: assert property (disable iff (1'b0)
      RST |=> !PREADY && !PSLVERR && !SO && !WIP_OUT)
      else $error("outputs active in reset");

   cover property (setup && !mapped);
   cover property (rd_st && PRDATA[STS_RECOVER]);
   cover property ($rose(WIP_OUT));
endmodule

// File: tb/sfsr_host.sv
// Host serial controller model sending command frames
`timescale 1ns/1ps
module sfsr_host
   import sfsr_pkg::*;
(
   input wire logic CLK,
   output logic CS_N,
   output logic SCK,
   output logic SI,
   input wire logic SO
);
   initial begin
      CS_N <= 1'b1;
      SCK <= 1'b0;
      SI <= 1'b1;
   end

   // ----------------------------------------------------------------
   // One frame: opcode, zero bytes, adr as last address byte
   // ----------------------------------------------------------------
   task automatic frame(input logic [7:0] op, input int nb,
                        input logic [7:0] adr, output logic [7:0] rx);
      logic [7:0] b;
      @(posedge CLK);
      CS_N <= 1'b0;
      for (int i = 0; i < nb; i++) begin
         b = (i == 0) ? op : (i == 3) ? adr : IDLE_BYTE;
         for (int j = 7; j >= 0; j--) begin
            SI <= b[j];
            repeat (3) @(posedge CLK);
            SCK <= 1'b1;
            rx = {rx[6:0], SO};
            repeat (3) @(posedge CLK);
            SCK <= 1'b0;
         end
      end
      repeat (3) @(posedge CLK);
      CS_N <= 1'b1;
      SI <= ~SI; // Released line must not keep its last bit
      repeat (4) @(posedge CLK);
   endtask
endmodule

// File: tb/tb_sfsr_top.sv
// Self-checking bench for the serial flash soft reset block
`timescale 1ns/1ps
module tb_sfsr_top;
   import sfsr_pkg::*;
   localparam int RECOVERY_NS = 2000;
   logic CLK = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, wip_out, cs_n, sck, si, so;
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [31:0] r;
   logic e;
   logic [7:0] b;

   initial forever #2 CLK = ~CLK;

   sfsr_host host (.CLK(CLK), .CS_N(cs_n), .SCK(sck), .SI(si), .SO(so));
   sfsr_top #(.RECOVERY_NS(RECOVERY_NS)) dut (.CLK(CLK), .RST(rst),
      .CS_N(cs_n), .SCK(sck), .SI(si), .SO(so), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .WIP_OUT(wip_out));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge CLK);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge CLK);
      penable <= 1'b1;
      do begin
         @(posedge CLK);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(r, exp);
   endtask

   task automatic sq(input logic [7:0] op, input int nb,
                     input logic [7:0] adr, input logic [7:0] exp);
      host.frame(op, nb, adr, b);
      chk({24'h00_0000, b}, {24'h00_0000, exp});
   endtask

   task automatic results;
      if (num_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         results();
      end
   end

   initial begin
      repeat (8) @(posedge CLK);
      rst <= 1'b0;
      rd(ADDR_STATUS, 32'h0000_0200);
      rd(ADDR_VOLATILE, 32'h0000_0000);
      rd(ADDR_CYCLE, 32'h0000_0100);
      rd(ADDR_CTRL, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      chk({31'h0000_0000, e}, 32'h0000_0001);
      sq(OP_READ_STATUS_HI, 2, 8'h00, 8'h02);
      sq(OP_READ_STATUS_LO, 2, 8'h00, 8'h00);
      sq(OP_READ_ARRAY, 5, 8'h00, ERASED_BYTE);
      sq(OP_READ_ARRAY, 6, 8'h7F, ERASED_BYTE);
      sq(OP_READ_PARAM_TABLE, 6, 8'h00, 8'h53);
      sq(OP_READ_PARAM_TABLE, 8, 8'h00, 8'h44);
      sq(OP_READ_PARAM_TABLE, 6, 8'h10, ERASED_BYTE);
      // Short internal cycle
      apb(1'b1, ADDR_CYCLE, 32'h0000_0014);
      apb(1'b1, ADDR_CTRL, 32'h0000_0001);
      rd(ADDR_STATUS, 32'h0000_0201);
      chk({31'h0000_0000, wip_out}, 32'h0000_0001);
      repeat (30) @(posedge CLK);
      rd(ADDR_STATUS, 32'h0000_0200);
      chk({31'h0000_0000, wip_out}, 32'h0000_0000);
      // Busy, latched and suspended before the reset
      apb(1'b1, ADDR_CYCLE, 32'h0000_0100);
      apb(1'b1, ADDR_CTRL, 32'h0000_0001);
      host.frame(OP_WRITE_ENABLE, 1, 8'h00, b);
      apb(1'b1, ADDR_VOLATILE, 32'h0037_FFFF);
      rd(ADDR_STATUS, 32'h0000_8603);
      host.frame(OP_ARM_RESET, 1, 8'h00, b);
      host.frame(OP_WRITE_ENABLE, 1, 8'h00, b);
      host.frame(OP_RESET, 1, 8'h00, b);
      rd(ADDR_STATUS, 32'h0000_8603);
      host.frame(OP_ARM_RESET, 2, 8'h00, b);
      host.frame(OP_RESET, 1, 8'h00, b);
      rd(ADDR_STATUS, 32'h0000_8603);
      host.frame(OP_ARM_RESET, 1, 8'h00, b);
      host.frame(OP_RESET, 1, 8'h00, b);
      rd(ADDR_STATUS, 32'h0002_0200);
      rd(ADDR_VOLATILE, 32'h0000_0000);
      chk({31'h0000_0000, wip_out}, 32'h0000_0000);
      // Commands during recovery must do nothing
      host.frame(OP_WRITE_ENABLE, 1, 8'h00, b);
      apb(1'b1, ADDR_CTRL, 32'h0000_0001);
      rd(ADDR_STATUS, 32'h0002_0200);
      for (int k = 0; k < 200 && r[STS_RECOVER] !== 1'b0; k++) begin
         apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      end
      host.frame(OP_WRITE_ENABLE, 1, 8'h00, b);
      rd(ADDR_STATUS, 32'h0000_0202);
      results();
   end
endmodule

bind sfsr_top sfsr_sva #(.RECOVERY_NS(RECOVERY_NS)) u_sva (.CLK(CLK),
   .RST(RST), .CS_N(CS_N), .SCK(SCK), .SI(SI), .SO(SO), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .WIP_OUT(WIP_OUT));
